// ---- hdl/pse_ctrl.sv ----
// Reset sources, strap latching, serial address answer and per-port mode control
//
// Function
// R1: Slave address is 010 followed by the four latched address straps.
// R2: Address straps captured at supply rise and every reset, then held.
// R3: Serial data received on one line, answered on a separate line.
// R4: Low fast-off input of a port switches that port's power off.
// R5: After reset, mode strap high gives auto, low gives shutdown.
// R6: Software mode writes override auto even while the mode strap stays high.
// R7: Sine loss shuts down and blocks ports having AC disconnect enabled.
// R8: Reset from supply rise, reset pin pulse, software bit, thermal shutdown.
// R9: Any reset restores register defaults and samples mode and cadence straps.
// R10: Strap changes outside reset are ignored.
// R11: No address acknowledge while a reset condition persists.
// R12: Port reset bit powers port off and clears its events and status.
// R13: With cadence on, wait 2 to 2.4 s after failed detection.
// R14: Cadence enable bit loaded from cadence strap at reset.
// R15: Four identical independent port state machines with four modes.
// R16: Semi-auto detects on request repeatedly, powers only on command.
// R17: Changing among auto, semi and manual keeps port operation going.
// R18: Shutdown stops the port at once; idle until shutdown left.
// R19: Mode codes: 11 auto, 10 semi, 01 manual, 00 shutdown.
// R20: Auto detects and powers unaided, retrying until a valid load.
// R21: Entering shutdown clears that port's event and status bits.
// R22: Controller holds reset pin low at least 300 us.
// R23: Software and port reset bits clear themselves, read back zero.
`timescale 1ns/1ps
`include "pse_ctrl_regs.svh"

module pse_ctrl #(
	parameter int unsigned CADENCE_CYC = `PSE_CADENCE_MS * `PSE_CLK_KHZ,
	parameter int unsigned SINE_WATCH_CYC = `PSE_SINE_WATCH_MS * `PSE_CLK_KHZ
) (
	input  wire logic        ref_clk,             // System clock
	input  wire logic        nrst,                // Power-on reset, active low
	input  wire logic        supply_ok,           // Supplies above lockout
	input  wire logic        reset_pin_n,         // Hardware reset pin
	input  wire logic        thermal_shutdown,    // Overtemperature
	input  wire logic [3:0]  slave_addr_straps,   // Low address straps
	input  wire logic        auto_strap,          // Startup mode strap
	input  wire logic        cadence_strap,       // Midspan strap
	input  wire logic [3:0]  port_fast_off_n,     // Fast shutdown pins
	input  wire logic        ac_sense_sine_input, // Sine above loss threshold
	input  wire logic [3:0]  det_done,            // Detection finished pulse
	input  wire logic [3:0]  det_valid,           // Detection found valid load
	input  wire logic        scl,                 // Serial clock pin
	input  wire logic        serial_data_rx_line, // Serial data in
	output logic             serial_data_tx_line, // Serial data out, low is ack
	output logic [3:0]       gate_on,             // Port power switch drive
	output logic [3:0]       det_probe,           // Run detection on port
	output logic             in_reset,            // Device held in reset
	input  wire logic        psel,                // APB select
	input  wire logic        penable,             // APB enable
	input  wire logic        pwrite,              // APB write
	input  wire logic [7:0]  paddr,               // APB byte address
	input  wire logic [31:0] pwdata,              // APB write data
	output logic [31:0]      prdata,              // APB read data
	output logic             pready,              // APB ready
	output logic             pslverr              // APB error
);

	// Two-flop synchronisers for every pin
	localparam int NSYNC = 16;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;

	assign pin_raw = {supply_ok, reset_pin_n, thermal_shutdown, slave_addr_straps,
		auto_strap, cadence_strap, port_fast_off_n, ac_sense_sine_input, scl,
		serial_data_rx_line};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	logic       supply_s;
	logic       rstpin_s;
	logic       therm_s;
	logic [3:0] addr_s;
	logic       auto_s;
	logic       cad_s;
	logic [3:0] fast_n_s;
	logic       sine_s;
	logic       scl_s;
	logic       sda_s;

	assign {supply_s, rstpin_s, therm_s, addr_s, auto_s, cad_s, fast_n_s, sine_s,
		scl_s, sda_s} = sync2_r;

	// Reset sequencing
	logic sys_rst_r;
	logic sw_rst_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sys_rst_r <= 1'b1;
		end else begin
			// Held while any cause persists; R22 pulse width relies on the pin owner
			sys_rst_r <= !supply_s || !rstpin_s || therm_s || sw_rst_r; // [R8] [R22]
		end
	end

	// Straps follow the pins during reset and freeze at its release
	logic [6:0] slave_addr_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			slave_addr_r <= '0;
		end else if (sys_rst_r) begin
			slave_addr_r <= {`PSE_ADDR_UPPER, addr_s}; // [R1] [R2] [R10]
		end
	end

	// APB slave, one wait state
	logic [5:0]  reg_idx;
	logic        acc_en;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [31:0] rd_val;

	logic [7:0] mode_r;
	logic       midspan_r;
	logic [3:0] acd_en_r;
	logic [3:0] detect_request_r;
	logic [3:0] pwr_cmd_r;
	logic [3:0] port_rst_r;
	logic [3:0] det_end_r;
	logic [3:0] det_good_r;
	logic       sine_fail_r;
	logic [3:0] det_clr;
	logic [3:0] shut_enter;

	assign reg_idx = paddr[7:2];
	assign acc_en  = psel && penable && pready;
	assign wr_en   = acc_en && pwrite && addr_ok;
	assign rd_en   = acc_en && !pwrite && addr_ok;

	always_comb begin
		addr_ok = (paddr[1:0] == 2'h0);
		rd_val  = '0;
		case (reg_idx)
			`PSE_IDX_EVENT:   rd_val[3:0] = det_end_r;
			`PSE_IDX_STATUS:  rd_val[7:0] = {det_good_r, gate_on};
			`PSE_IDX_ADDR:    rd_val[6:0] = slave_addr_r;
			`PSE_IDX_MIDSPAN: rd_val[`PSE_MIDSPAN_BIT] = midspan_r;
			`PSE_IDX_MODE:    rd_val[7:0] = mode_r;
			`PSE_IDX_ACD:     rd_val[4:0] = {sine_fail_r, acd_en_r};
			`PSE_IDX_DETEN:   rd_val[3:0] = detect_request_r;
			`PSE_IDX_PWRON:   rd_val = '0;
			`PSE_IDX_RESET:   rd_val = '0; // [R23]
			default:          addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite && addr_ok) ? rd_val : '0;
			pslverr <= psel && penable && !pready && !addr_ok;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_r    <= `PSE_MODE_RST_SHUT;
			midspan_r <= 1'b0;
			acd_en_r  <= `PSE_ACD_RST;
		end else if (sys_rst_r) begin
			mode_r    <= auto_s ? `PSE_MODE_RST_AUTO : `PSE_MODE_RST_SHUT; // [R5] [R9]
			midspan_r <= cad_s; // [R14] [R9]
			acd_en_r  <= `PSE_ACD_RST; // [R9]
		end else if (wr_en) begin
			if (reg_idx == `PSE_IDX_MODE) begin
				mode_r <= pwdata[7:0]; // [R6]
			end
			if (reg_idx == `PSE_IDX_MIDSPAN) begin
				midspan_r <= pwdata[`PSE_MIDSPAN_BIT];
			end
			if (reg_idx == `PSE_IDX_ACD) begin
				acd_en_r <= pwdata[3:0];
			end
		end
	end

	// Self-clearing command pulses
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pwr_cmd_r  <= '0;
			port_rst_r <= '0;
			sw_rst_r   <= 1'b0;
		end else begin
			pwr_cmd_r  <= (wr_en && reg_idx == `PSE_IDX_PWRON && !sys_rst_r) ?
				pwdata[3:0] : 4'h0; // [R23]
			port_rst_r <= (wr_en && reg_idx == `PSE_IDX_RESET && !sys_rst_r) ?
				pwdata[3:0] : 4'h0; // [R12] [R23]
			sw_rst_r   <= wr_en && reg_idx == `PSE_IDX_RESET &&
				pwdata[`PSE_SWRST_BIT] && !sys_rst_r; // [R8] [R23]
		end
	end

	// Sine watchdog: no high level for a window means the peak is lost
	logic [21:0] sine_cnt_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sine_cnt_r  <= '0;
			sine_fail_r <= 1'b0;
		end else if (sine_s) begin
			sine_cnt_r  <= '0;
			sine_fail_r <= 1'b0;
		end else if (sine_cnt_r == 22'(SINE_WATCH_CYC - 1)) begin
			sine_fail_r <= 1'b1; // [R7]
		end else begin
			sine_cnt_r <= sine_cnt_r + 22'h1;
		end
	end

	// Detection enables; software sets, port machines clear pushbuttons
	logic [3:0] deten_wr;

	assign deten_wr = (wr_en && reg_idx == `PSE_IDX_DETEN) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			detect_request_r <= `PSE_DETEN_RST_SHUT;
		end else if (sys_rst_r) begin
			detect_request_r <= auto_s ? `PSE_DETEN_RST_AUTO : `PSE_DETEN_RST_SHUT;
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (wr_en && reg_idx == `PSE_IDX_MODE &&
						pwdata[2*p +: 2] != mode_r[2*p +: 2]) begin
					detect_request_r[p] <= (pwdata[2*p +: 2] == `PSE_MODE_AUTO);
				end else if (wr_en && reg_idx == `PSE_IDX_DETEN) begin
					detect_request_r[p] <= deten_wr[p];
				end else if (det_clr[p]) begin
					detect_request_r[p] <= 1'b0;
				end
			end
		end
	end

	// Events and status; a set wins over a read-clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			det_end_r  <= '0;
			det_good_r <= '0;
		end else if (sys_rst_r) begin
			det_end_r  <= '0; // [R9]
			det_good_r <= '0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (port_rst_r[p] || shut_enter[p]) begin
					det_end_r[p]  <= 1'b0; // [R12] [R21]
					det_good_r[p] <= 1'b0;
				end else if (det_probe[p] && det_done[p]) begin
					det_end_r[p]  <= 1'b1;
					det_good_r[p] <= det_valid[p];
				end else if (rd_en && reg_idx == `PSE_IDX_EVENT) begin
					det_end_r[p] <= 1'b0;
				end
			end
		end
	end

	// Per-port operating state machines
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_port // [R15]
			logic [1:0]                   mode;
			logic                         kill;
			logic                         blocked;
			logic [27:0]                  wait_cnt_r;
			pse_ctrl_pkg::pse_port_state_e state_r;
			pse_ctrl_pkg::pse_port_state_e state_nxt;

			assign mode    = mode_r[2*gp +: 2]; // [R19]
			assign kill    = sys_rst_r || port_rst_r[gp] || mode == `PSE_MODE_SHUT; // [R18]
			assign blocked = !fast_n_s[gp] || (acd_en_r[gp] && sine_fail_r); // [R4] [R7]
			assign shut_enter[gp] = wr_en && reg_idx == `PSE_IDX_MODE &&
				pwdata[2*gp +: 2] == `PSE_MODE_SHUT && mode != `PSE_MODE_SHUT; // [R21]
			assign det_clr[gp] = mode == `PSE_MODE_MANUAL && state_r == pse_ctrl_pkg::PS_DETECT
				&& det_done[gp];

			always_comb begin
				state_nxt = state_r;
				case (state_r)
					pse_ctrl_pkg::PS_IDLE: begin
						if (pwr_cmd_r[gp] && !blocked) begin
							state_nxt = pse_ctrl_pkg::PS_POWERED;
						end else if (detect_request_r[gp]) begin
							state_nxt = pse_ctrl_pkg::PS_DETECT; // [R20]
						end
					end
					pse_ctrl_pkg::PS_DETECT: begin
						if (pwr_cmd_r[gp] && !blocked) begin
							state_nxt = pse_ctrl_pkg::PS_POWERED;
						end else if (det_done[gp] && det_valid[gp]) begin
							if (mode == `PSE_MODE_AUTO && !blocked) begin
								state_nxt = pse_ctrl_pkg::PS_POWERED; // [R20]
							end else begin
								state_nxt = pse_ctrl_pkg::PS_IDLE; // [R16]
							end
						end else if (det_done[gp]) begin
							if (midspan_r && mode != `PSE_MODE_MANUAL) begin
								state_nxt = pse_ctrl_pkg::PS_WAIT; // [R13]
							end else begin
								state_nxt = pse_ctrl_pkg::PS_IDLE;
							end
						end
					end
					pse_ctrl_pkg::PS_WAIT: begin
						if (pwr_cmd_r[gp] && !blocked) begin
							state_nxt = pse_ctrl_pkg::PS_POWERED;
						end else if (wait_cnt_r == 28'(CADENCE_CYC - 1)) begin
							state_nxt = pse_ctrl_pkg::PS_IDLE; // [R13]
						end
					end
					pse_ctrl_pkg::PS_POWERED: begin
						if (blocked) begin
							state_nxt = pse_ctrl_pkg::PS_IDLE; // [R4] [R7]
						end
					end
					default: state_nxt = pse_ctrl_pkg::PS_IDLE;
				endcase
			end

			// Mode writes among auto, semi, manual leave the state alone
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					state_r       <= pse_ctrl_pkg::PS_IDLE;
					gate_on[gp]   <= 1'b0;
					det_probe[gp] <= 1'b0;
				end else if (kill) begin
					state_r       <= pse_ctrl_pkg::PS_IDLE; // [R12] [R18]
					gate_on[gp]   <= 1'b0;
					det_probe[gp] <= 1'b0;
				end else begin
					state_r       <= state_nxt; // [R17]
					gate_on[gp]   <= state_nxt == pse_ctrl_pkg::PS_POWERED;
					det_probe[gp] <= state_nxt == pse_ctrl_pkg::PS_DETECT;
				end
			end

			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					wait_cnt_r <= '0;
				end else if (kill || state_r != pse_ctrl_pkg::PS_WAIT) begin
					wait_cnt_r <= '0;
				end else begin
					wait_cnt_r <= wait_cnt_r + 28'h1;
				end
			end
		end
	endgenerate

	// Serial address answer on the separate output line
	logic                         scl_d_r;
	logic                         sda_d_r;
	logic [3:0]                   bit_cnt_r;
	logic [7:0]                   shift_r;
	pse_ctrl_pkg::pse_ser_state_e ser_r;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         start_c;
	logic                         stop_c;

	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s; // [R3]
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ser_r               <= pse_ctrl_pkg::SER_IDLE;
			bit_cnt_r           <= '0;
			shift_r             <= '0;
			serial_data_tx_line <= 1'b1;
		end else if (start_c) begin
			ser_r               <= pse_ctrl_pkg::SER_ADDR;
			bit_cnt_r           <= '0;
			serial_data_tx_line <= 1'b1;
		end else if (stop_c) begin
			ser_r               <= pse_ctrl_pkg::SER_IDLE;
			serial_data_tx_line <= 1'b1;
		end else begin
			case (ser_r)
				pse_ctrl_pkg::SER_ADDR: begin
					if (scl_rise && bit_cnt_r != 4'h8) begin
						shift_r   <= {shift_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						if (shift_r[7:1] == slave_addr_r && !sys_rst_r) begin
							serial_data_tx_line <= 1'b0; // [R1] [R11] [R3]
							ser_r               <= pse_ctrl_pkg::SER_ACK;
						end else begin
							ser_r <= pse_ctrl_pkg::SER_IDLE;
						end
					end
				end
				pse_ctrl_pkg::SER_ACK: begin
					if (scl_fall) begin
						serial_data_tx_line <= 1'b1;
						ser_r               <= pse_ctrl_pkg::SER_IDLE;
					end
				end
				pse_ctrl_pkg::SER_IDLE: serial_data_tx_line <= 1'b1;
				default: ser_r <= pse_ctrl_pkg::SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			in_reset <= 1'b1;
		end else begin
			in_reset <= sys_rst_r;
		end
	end

endmodule

// ---- hdl/pse_ctrl_regs.svh ----
// Register indexes, field positions, reset values, clock rate and timing in ms
`ifndef PSE_CTRL_REGS_SVH
`define PSE_CTRL_REGS_SVH

// Register indexes; byte address is four times the index
`define PSE_IDX_EVENT      6'h05
`define PSE_IDX_STATUS     6'h0c
`define PSE_IDX_ADDR       6'h10
`define PSE_IDX_MIDSPAN    6'h11
`define PSE_IDX_MODE       6'h12
`define PSE_IDX_ACD        6'h13
`define PSE_IDX_DETEN      6'h14
`define PSE_IDX_PWRON      6'h19
`define PSE_IDX_RESET      6'h1a

// Field positions
`define PSE_MIDSPAN_BIT    1
`define PSE_SWRST_BIT      4
`define PSE_ACD_FAIL_BIT   4

// Mode codes of the two-bit per-port field
`define PSE_MODE_AUTO      2'h3
`define PSE_MODE_SEMI      2'h2
`define PSE_MODE_MANUAL    2'h1
`define PSE_MODE_SHUT      2'h0

// Reset values
`define PSE_MODE_RST_AUTO  8'hff
`define PSE_MODE_RST_SHUT  8'h00
`define PSE_DETEN_RST_AUTO 4'hf
`define PSE_DETEN_RST_SHUT 4'h0
`define PSE_ACD_RST        4'h0

// Fixed upper slave address bits
`define PSE_ADDR_UPPER     3'h2

// Timing and sine loss threshold
`define PSE_CLK_KHZ        100000
`define PSE_CADENCE_MS     2200
`define PSE_SINE_WATCH_MS  20
`define PSE_SINE_LOSS_THRESHOLD_MV 2000

`endif

// ---- hdl/pse_ctrl_pkg.sv ----
// Types shared by the reset and port mode controller
package pse_ctrl_pkg;

	typedef enum logic [1:0] {
		PS_IDLE,
		PS_DETECT,
		PS_WAIT,
		PS_POWERED
	} pse_port_state_e;

	typedef enum logic [1:0] {
		SER_IDLE,
		SER_ADDR,
		SER_ACK
	} pse_ser_state_e;

endpackage

// ---- test/pse_ctrl_assertions.sv ----
// Checker for the APB answer, port power and serial ack rules
`timescale 1ns/1ps
`include "pse_ctrl_regs.svh"
module pse_ctrl_assertions #(
	parameter int unsigned CADENCE_CYC    = 50,
	parameter int unsigned SINE_WATCH_CYC = 40
) (
	input wire logic        ref_clk,             // Clock
	input wire logic        nrst,                // Reset, active low
	input wire logic        psel,                // APB select
	input wire logic        penable,             // APB enable
	input wire logic        pwrite,              // APB write
	input wire logic [7:0]  paddr,               // APB address
	input wire logic [31:0] pwdata,              // APB write data
	input wire logic [31:0] prdata,              // APB read data
	input wire logic        pready,              // APB ready
	input wire logic        pslverr,             // APB error
	input wire logic [3:0]  port_fast_off_n,     // Fast off pins
	input wire logic [3:0]  gate_on,             // Port power
	input wire logic [3:0]  det_probe,           // Detection running
	input wire logic        in_reset,            // Reset held
	input wire logic        serial_data_tx_line  // Serial answer
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic wr_ok;
	assign wr_ok = psel && penable && pready && pwrite && !in_reset;
	property p_ready_one;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_rdata_idle;
		!pready || pwrite || pslverr |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data leak");
	property p_err_ready;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_fast_off;
		$stable(port_fast_off_n) [*4] |-> (gate_on & ~port_fast_off_n) == 4'h0;
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("power on fast off");
	property p_reset_gate;
		$rose(in_reset) |-> gate_on == 4'h0;
	endproperty
	a_reset_gate: assert property (p_reset_gate) else $error("power in reset");
	property p_nack_reset;
		in_reset |-> serial_data_tx_line;
	endproperty
	a_nack_reset: assert property (p_nack_reset) else $error("ack in reset");
	property p_shut;
		wr_ok && paddr == {`PSE_IDX_MODE, 2'b00} && pwdata[1:0] == `PSE_MODE_SHUT
			|-> ##2 !gate_on[0] && !det_probe[0];
	endproperty
	a_shut: assert property (p_shut) else $error("port busy in shutdown");
	property p_port_rst;
		wr_ok && paddr == {`PSE_IDX_RESET, 2'b00} && pwdata[0] |-> ##2 !gate_on[0];
	endproperty
	a_port_rst: assert property (p_port_rst) else $error("port reset kept power");
endmodule

bind pse_ctrl pse_ctrl_assertions #(
	.CADENCE_CYC   (CADENCE_CYC),
	.SINE_WATCH_CYC(SINE_WATCH_CYC)
) i_chk (
	.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .port_fast_off_n, .gate_on, .det_probe, .in_reset, .serial_data_tx_line
);

// ---- test/pse_mcu_model.sv ----
// Serial link controller model sending address frames
`timescale 1ns/1ps
module pse_mcu_model (
	input  wire logic ref_clk,  // Pacing clock
	output logic      scl,      // Serial clock, still and high when idle
	output logic      sda,      // Data toward the device, pulled up
	input  wire logic sda_back  // Separate answer line, low is ack
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Half of a 160 ns link period
	task automatic hp();
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic probe(input logic [6:0] a, output logic ack);
		logic [7:0] b;
		b = {a, 1'b0};
		sda <= 1'b0;
		hp();
		scl <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sda <= b[i];
			hp();
			scl <= 1'b1;
			hp();
			scl <= 1'b0;
		end
		sda <= 1'b1;
		hp();
		scl <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ack = !sda_back;
		hp();
		scl <= 1'b0;
		sda <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sda <= 1'b1;
		hp();
	endtask
endmodule

// ---- test/tb.sv ----
// Testbench for the reset and port mode controller
`timescale 1ns/1ps
`include "pse_ctrl_regs.svh"
module tb;
	localparam int CAD = 50;
	localparam int DP = 0;
	localparam int GO = 1;
	localparam int IR = 2;
	logic ref_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1, reset_pin_n = 1'b1;
	logic thermal_shutdown = 1'b0, auto_strap = 1'b1, cadence_strap = 1'b1;
	logic [3:0] slave_addr_straps = 4'h5, port_fast_off_n = 4'hf;
	logic ac_sense_sine_input = 1'b1;
	logic [3:0] det_done = 4'h0, det_valid = 4'h0, gate_on, det_probe;
	logic scl, serial_data_rx_line, serial_data_tx_line, in_reset;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e, ack;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int error_cnt = 0, total_checks = 0, n;
	always #5 ref_clk = ~ref_clk;
	pse_ctrl #(.CADENCE_CYC(CAD), .SINE_WATCH_CYC(40)) i_dut (
		.ref_clk, .nrst, .supply_ok, .reset_pin_n, .thermal_shutdown, .slave_addr_straps,
		.auto_strap, .cadence_strap, .port_fast_off_n, .ac_sense_sine_input, .det_done,
		.det_valid, .scl, .serial_data_rx_line, .serial_data_tx_line, .gate_on, .det_probe,
		.in_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
	);
	pse_mcu_model i_mcu (.ref_clk, .scl, .sda(serial_data_rx_line),
		.sda_back(serial_data_tx_line));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, s, x);
		end
	endtask
	task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) error_cnt++;
	endtask
	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		xfer(1'b1, ix, d);
	endtask
	task automatic rd(input logic [5:0] ix, input logic [31:0] x);
		xfer(1'b0, ix, 32'h0);
		chk(q, x);
	endtask
	function automatic logic sig(input int s);
		case (s)
			DP: return det_probe[0];
			GO: return gate_on[0];
			default: return in_reset;
		endcase
	endfunction
	task automatic wt(input int s, input logic v);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (sig(s) !== v && k < 1000);
		chk(32'(sig(s)), 32'(v));
	endtask
	task automatic dd(input logic v);
		det_done <= 4'h1;
		det_valid <= {3'h0, v};
		@(posedge ref_clk);
		det_done <= 4'h0;
	endtask
	task automatic cy(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		wt(IR, 1'b0);
		rd(`PSE_IDX_MODE, 32'hff);
		rd(`PSE_IDX_DETEN, 32'hf);
		rd(`PSE_IDX_MIDSPAN, 32'h2);
		rd(`PSE_IDX_ADDR, 32'h25);
		rd(`PSE_IDX_RESET, 32'h0);
		xfer(1'b0, 6'h3f, 32'h0);
		chk(32'(e), 32'h1);
		i_mcu.probe(7'h25, ack);
		chk(32'(ack), 32'h1);
		$display("end of reset values test");
		reset_pin_n <= 1'b0;
		slave_addr_straps <= 4'ha;
		auto_strap <= 1'b0;
		wt(IR, 1'b1);
		i_mcu.probe(7'h25, ack);
		chk(32'(ack), 32'h0);
		cy(30000);
		reset_pin_n <= 1'b1;
		wt(IR, 1'b0);
		auto_strap <= 1'b1;
		slave_addr_straps <= 4'h3;
		rd(`PSE_IDX_MODE, 32'h0);
		rd(`PSE_IDX_ADDR, 32'h2a);
		i_mcu.probe(7'h2a, ack);
		chk(32'(ack), 32'h1);
		i_mcu.probe(7'h25, ack);
		chk(32'(ack), 32'h0);
		$display("end of hardware reset test");
		wr(`PSE_IDX_MIDSPAN, 32'h0);
		wr(`PSE_IDX_MODE, 32'h3);
		rd(`PSE_IDX_MODE, 32'h3);
		wt(DP, 1'b1);
		dd(1'b0);
		cy(3);
		wt(DP, 1'b1);
		dd(1'b1);
		wt(GO, 1'b1);
		rd(`PSE_IDX_STATUS, 32'h11);
		rd(`PSE_IDX_EVENT, 32'h1);
		wr(`PSE_IDX_MODE, 32'h2);
		cy(5);
		chk(32'(gate_on), 32'h1);
		port_fast_off_n <= 4'he;
		wt(GO, 1'b0);
		port_fast_off_n <= 4'hf;
		wr(`PSE_IDX_DETEN, 32'h1);
		wt(DP, 1'b1);
		dd(1'b1);
		cy(4);
		chk(32'(gate_on), 32'h0);
		wt(DP, 1'b1);
		wr(`PSE_IDX_PWRON, 32'h1);
		wt(GO, 1'b1);
		wr(`PSE_IDX_RESET, 32'h1);
		wt(GO, 1'b0);
		rd(`PSE_IDX_STATUS, 32'h0);
		rd(`PSE_IDX_EVENT, 32'h0);
		rd(`PSE_IDX_RESET, 32'h0);
		wr(`PSE_IDX_PWRON, 32'h1);
		wt(GO, 1'b1);
		wr(`PSE_IDX_MODE, 32'h0);
		wt(GO, 1'b0);
		chk(32'(det_probe), 32'h0);
		rd(`PSE_IDX_STATUS, 32'h0);
		wr(`PSE_IDX_PWRON, 32'h1);
		cy(5);
		chk(32'(gate_on), 32'h0);
		$display("end of port mode test");
		wr(`PSE_IDX_MIDSPAN, 32'h2);
		wr(`PSE_IDX_MODE, 32'h3);
		wt(DP, 1'b1);
		dd(1'b0);
		wt(DP, 1'b0);
		n = 0;
		while (det_probe[0] !== 1'b1 && n < 500) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(n >= CAD * 20 / 22 && n <= CAD * 24 / 22), 32'h1);
		dd(1'b1);
		wt(GO, 1'b1);
		wr(`PSE_IDX_ACD, 32'h1);
		ac_sense_sine_input <= 1'b0;
		wt(GO, 1'b0);
		rd(`PSE_IDX_ACD, 32'h11);
		wr(`PSE_IDX_PWRON, 32'h1);
		cy(5);
		chk(32'(gate_on), 32'h0);
		ac_sense_sine_input <= 1'b1;
		$display("end of cadence and sine test");
		wr(`PSE_IDX_MODE, 32'h1);
		rd(`PSE_IDX_DETEN, 32'h0);
		wt(DP, 1'b1);
		dd(1'b0);
		wt(DP, 1'b0);
		cy(CAD + 10);
		chk(32'(det_probe), 32'h0);
		wr(`PSE_IDX_DETEN, 32'h1);
		wt(DP, 1'b1);
		dd(1'b1);
		wt(DP, 1'b0);
		chk(32'(gate_on), 32'h0);
		rd(`PSE_IDX_DETEN, 32'h0);
		$display("end of manual mode test");
		for (int i = 0; i < 3; i++) begin
			if (i == 2) begin
				wr(`PSE_IDX_RESET, 32'h10);
				wt(IR, 1'b1);
			end else begin
				supply_ok <= (i != 0);
				thermal_shutdown <= (i == 1);
				wt(IR, 1'b1);
				i_mcu.probe(7'h23, ack);
				chk(32'(ack), 32'h0);
				supply_ok <= 1'b1;
				thermal_shutdown <= 1'b0;
			end
			wt(IR, 1'b0);
			rd(`PSE_IDX_MODE, 32'hff);
			rd(`PSE_IDX_ACD, 32'h0);
		end
		rd(`PSE_IDX_RESET, 32'h0);
		$display("end of reset source test");
		stop_test();
	end
endmodule
